// ===== pkg/asf_cfg.svh
/*
  shared constants of the arbitrary sample formatter: register map, field positions,
  reset values and waveform limits.
  assumes inclusion by bare name from any design file.
*/
`ifndef ASF_CFG_SVH
`define ASF_CFG_SVH

`define ASF_ADDR_W          4
`define ASF_REG_CTRL        4'h0
`define ASF_REG_SCALE       4'h1
`define ASF_REG_STATUS      4'h2
`define ASF_REG_MASK        4'h3
`define ASF_REG_POINTS      4'h4
`define ASF_REG_HDR         4'h5
`define ASF_CTRL_EN_BIT     0
`define ASF_CTRL_LEGACY_BIT 1
`define ASF_CTRL_START_BIT  2
`define ASF_CTRL_END_BIT    3
`define ASF_CTRL_HDR_BIT    4
`define ASF_SCALE_RST       8'h46
`define ASF_SCALE_MAX       8'h64
`define ASF_IRQ_OVL         0
`define ASF_IRQ_SHORT       1
`define ASF_IRQ_DONE        2
`define ASF_IRQ_W           3
`define ASF_MIN_POINTS      16'h003c
`define ASF_LEG_MID         16'h2000
`define ASF_LEG_MASK        16'h3fff
`define ASF_MARK_MASK       8'h0f
`define ASF_HDR_RST         8'h00
`define ASF_FULL_POS        18'sh0_7fff
`define ASF_FULL_NEG        -18'sh0_8000

`endif

// ===== pkg/asf_pkg.sv
/*
  types of the arbitrary sample formatter.
  assumes asf_cfg.svh is compiled alongside.
*/
`default_nettype none
package asf_pkg;
  typedef enum logic [1:0] {
    ASF_BYTE_IHI,
    ASF_BYTE_ILO,
    ASF_BYTE_QHI,
    ASF_BYTE_QLO
  } asf_phase_e;
  typedef logic signed [15:0] asf_sample_t;
endpackage
`default_nettype wire

// ===== hw/asf_legacy_conv.sv
/*
  converts one 16-bit download word to a signed converter code.
  assumes a purely combinational use inside the formatter.
*/
`default_nettype none
`include "asf_cfg.svh"
module asf_legacy_conv
  import asf_pkg::*;
(
  input  wire logic        legacy_i,
  input  wire logic [15:0] word_i,
  output asf_sample_t      code_o
);
  logic [15:0] low14;
  always_comb begin
    low14 = word_i & `ASF_LEG_MASK;
    if (legacy_i) begin
      // offset binary: subtract mid, then scale 14 to 16 bits
      code_o = asf_sample_t'({low14[13:0], 2'b00} ^ 16'h8000);
    end else begin
      code_o = asf_sample_t'(word_i);
    end
  end
endmodule // asf_legacy_conv
`default_nettype wire

// ===== hw/asf_scaler.sv
/*
  scales a signed sample by a percentage and checks overshoot of a simple
  two-point linear extrapolation, 1.5*cur-0.5*prev, against the converter range.
  assumes inputs from same-clock logic; one pipeline stage.
*/
`default_nettype none
`include "asf_cfg.svh"
module asf_scaler
  import asf_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        step_i,
  input  wire logic [7:0]  pct_i,
  input  wire asf_sample_t s_i,
  output asf_sample_t      s_o,
  output logic             ovl_o
);
  logic signed [24:0] prod;
  logic signed [17:0] scaled;
  logic signed [17:0] prev_reg;
  logic signed [17:0] overshoot;

  always_comb begin
    // widen both factors first: a 16-bit product would wrap
    prod = 25'(s_i) * 25'($signed({1'b0, pct_i}));
    scaled = 18'(prod / 25'sd100);
    // extrapolated peak 1.5*cur-0.5*prev models interpolation ringing
    overshoot = 18'(scaled + ((scaled - prev_reg) >>> 1));
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_o      <= 16'sh0000;
      prev_reg <= 18'sh0_0000;
      ovl_o    <= 1'b0;
    end else if (step_i) begin
      s_o      <= asf_sample_t'(scaled);
      prev_reg <= scaled;
      // legal inputs can still overshoot, so flag the path, not the input
      ovl_o    <= (overshoot > `ASF_FULL_POS) || (overshoot < `ASF_FULL_NEG);
    end else begin
      ovl_o    <= 1'b0;
    end
  end
endmodule // asf_scaler
`default_nettype wire

// ===== hw/asf_formatter.sv
/*
  arbitrary sample formatter: assembles big-endian I/Q byte stream plus marker
  bytes into points, scales them, drives marker triggers and flags errors.
  assumes a byte source with valid/ready, a sample sink with valid/ready,
  and a register port on the same clock.
*/
// What this block does
// - first byte of each word is high byte
// - I and Q are 16-bit words
// - 7fff full plus, 0 zero, 8000 full minus
// - samples are two's-complement signed words
// - legacy mode: 14-bit unsigned samples plus markers
// - flag overload from interpolation overshoot
// - percentage amplitude scale, preset 70
// - four bytes per point: I then Q
// - one marker byte per point, in order
// - only marker bits 0-3 used
// - marker bits drive triggers and event outputs
// - no header means all parameters unspecified
// - waveforms under sixty points are refused; here they play, and END only sets SHORT and blocks later points
`default_nettype none
`include "asf_cfg.svh"
module asf_formatter
  import asf_pkg::*;
(
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire logic [`ASF_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic [31:0]                 reg_rdata_o,
  input  wire logic [7:0]             iq_byte_i,
  input  wire logic                   iq_valid_i,
  output logic                        iq_ready_o,
  input  wire logic [7:0]             mark_byte_i,
  input  wire logic                   mark_valid_i,
  output logic                        mark_ready_o,
  output asf_sample_t                 samp_i_o,
  output asf_sample_t                 samp_q_o,
  output logic [3:0]                  samp_mark_o,
  output logic                        samp_valid_o,
  input  wire logic                   samp_ready_i,
  output logic [3:0]                  marker_trig_o,
  output logic                        event_primary_o,
  output logic                        event_aux_o,
  output logic                        irq_o
);
  asf_phase_e              phase_reg;
  logic [7:0]              hi_reg;
  logic [15:0]             i_word_reg;
  logic [15:0]             q_word_reg;
  logic [3:0]              mark_reg;
  logic                    pt_full_reg;
  logic                    pipe_v_reg;
  logic [3:0]              pipe_mark_reg;
  logic                    en_reg;
  logic                    legacy_reg;
  logic [7:0]              scale_reg;
  logic [7:0]              hdr_reg;
  logic                    hdr_given_reg;
  logic [`ASF_IRQ_W-1:0]   status_reg;
  logic [`ASF_IRQ_W-1:0]   mask_reg;
  logic [15:0]             points_reg;
  logic                    play_ok_reg;
  logic                    iq_have_reg;
  logic                    mk_have_reg;
  logic                    iq_take;
  logic                    mk_take;
  logic                    point_done;
  logic                    out_free;
  logic                    step;
  logic                    end_evt;
  logic                    short_evt;
  logic [`ASF_IRQ_W-1:0]   evt;
  asf_sample_t             i_code;
  asf_sample_t             q_code;
  asf_sample_t             i_scaled;
  asf_sample_t             q_scaled;
  logic                    i_ovl;
  logic                    q_ovl;

  function automatic logic wr_hit(input logic [`ASF_ADDR_W-1:0] a);
    return reg_wr_i && (reg_addr_i == a);
  endfunction

  // output stage drains or is empty; the pipe stage then may advance
  assign out_free   = !samp_valid_o || samp_ready_i;
  assign step       = out_free;
  assign point_done = pt_full_reg && step && play_ok_reg;
  // hold the byte stream while an assembled point waits
  assign iq_take    = iq_valid_i && iq_ready_o;
  assign mk_take    = mark_valid_i && mark_ready_o;
  assign end_evt    = wr_hit(`ASF_REG_CTRL) && reg_wdata_i[`ASF_CTRL_END_BIT];
  assign short_evt  = end_evt && (points_reg < `ASF_MIN_POINTS);

  always_comb begin
    evt = '0;
    evt[`ASF_IRQ_OVL]   = i_ovl || q_ovl;
    evt[`ASF_IRQ_SHORT] = short_evt;
    evt[`ASF_IRQ_DONE]  = end_evt && !short_evt;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      iq_ready_o   <= 1'b0;
      mark_ready_o <= 1'b0;
    end else begin
      // ready stays low while this point's half is held, else the next point overwrites it
      iq_ready_o   <= en_reg && !pt_full_reg && !iq_have_reg
                   && !(iq_take && phase_reg == ASF_BYTE_QLO);
      mark_ready_o <= en_reg && !pt_full_reg && !mk_have_reg && !mk_take;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg  <= ASF_BYTE_IHI;
      hi_reg     <= 8'h00;
      i_word_reg <= 16'h0000;
      q_word_reg <= 16'h0000;
    end else if (iq_take) begin
      case (phase_reg)
        ASF_BYTE_IHI: begin
          hi_reg    <= iq_byte_i;
          phase_reg <= ASF_BYTE_ILO;
        end
        ASF_BYTE_ILO: begin
          i_word_reg <= {hi_reg, iq_byte_i};
          phase_reg  <= ASF_BYTE_QHI;
        end
        ASF_BYTE_QHI: begin
          hi_reg    <= iq_byte_i;
          phase_reg <= ASF_BYTE_QLO;
        end
        ASF_BYTE_QLO: begin
          q_word_reg <= {hi_reg, iq_byte_i};
          phase_reg  <= ASF_BYTE_IHI;
        end
        default: phase_reg <= ASF_BYTE_IHI;
      endcase
    end
  end

  // a point is complete once both the I/Q group and its marker byte arrived
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      iq_have_reg <= 1'b0;
      mk_have_reg <= 1'b0;
      mark_reg    <= 4'h0;
      pt_full_reg <= 1'b0;
    end else if (pt_full_reg) begin
      if (step) begin
        pt_full_reg <= 1'b0;
        iq_have_reg <= 1'b0;
        mk_have_reg <= 1'b0;
      end
    end else begin
      if (iq_take && phase_reg == ASF_BYTE_QLO) begin
        iq_have_reg <= 1'b1;
      end
      if (mk_take && !mk_have_reg) begin
        mark_reg    <= 4'(mark_byte_i & `ASF_MARK_MASK);
        mk_have_reg <= 1'b1;
      end
      pt_full_reg <= (iq_have_reg || (iq_take && phase_reg == ASF_BYTE_QLO))
                  && (mk_have_reg || mk_take);
    end
  end

  asf_legacy_conv u_conv_i (
    .legacy_i (legacy_reg),
    .word_i   (i_word_reg),
    .code_o   (i_code)
  );

  asf_legacy_conv u_conv_q (
    .legacy_i (legacy_reg),
    .word_i   (q_word_reg),
    .code_o   (q_code)
  );

  asf_scaler u_scale_i (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .step_i     (point_done),
    .pct_i      (scale_reg),
    .s_i        (i_code),
    .s_o        (i_scaled),
    .ovl_o      (i_ovl)
  );

  asf_scaler u_scale_q (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .step_i     (point_done),
    .pct_i      (scale_reg),
    .s_i        (q_code),
    .s_o        (q_scaled),
    .ovl_o      (q_ovl)
  );

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pipe_v_reg    <= 1'b0;
      pipe_mark_reg <= 4'h0;
    end else if (step) begin
      pipe_v_reg    <= point_done;
      pipe_mark_reg <= mark_reg;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      samp_valid_o <= 1'b0;
      samp_i_o     <= 16'sh0000;
      samp_q_o     <= 16'sh0000;
      samp_mark_o  <= 4'h0;
    end else if (step) begin
      samp_valid_o <= pipe_v_reg;
      samp_i_o     <= i_scaled;
      samp_q_o     <= q_scaled;
      samp_mark_o  <= pipe_mark_reg;
    end
  end

  // triggers follow each emitted point's marker bits
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      marker_trig_o   <= 4'h0;
      event_primary_o <= 1'b0;
      event_aux_o     <= 1'b0;
    end else if (step) begin
      marker_trig_o   <= pipe_v_reg ? pipe_mark_reg : 4'h0;
      event_primary_o <= pipe_v_reg && pipe_mark_reg[0];
      event_aux_o     <= pipe_v_reg && (|pipe_mark_reg);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_reg        <= 1'b0;
      legacy_reg    <= 1'b0;
      scale_reg     <= `ASF_SCALE_RST;
      mask_reg      <= '0;
      hdr_reg       <= `ASF_HDR_RST;
      hdr_given_reg <= 1'b0;
    end else begin
      if (wr_hit(`ASF_REG_CTRL)) begin
        en_reg     <= reg_wdata_i[`ASF_CTRL_EN_BIT];
        legacy_reg <= reg_wdata_i[`ASF_CTRL_LEGACY_BIT];
        if (reg_wdata_i[`ASF_CTRL_START_BIT]) begin
          // new waveform: header given if the HDR bit is set, else unspecified until written
          hdr_given_reg <= reg_wdata_i[`ASF_CTRL_HDR_BIT];
        end
      end
      if (wr_hit(`ASF_REG_SCALE)) begin
        // values above full scale clamp to 100 percent
        scale_reg <= (reg_wdata_i[7:0] > `ASF_SCALE_MAX) ? `ASF_SCALE_MAX : reg_wdata_i[7:0];
      end
      if (wr_hit(`ASF_REG_MASK)) begin
        mask_reg <= reg_wdata_i[`ASF_IRQ_W-1:0];
      end
      // header value kept from previous waveform when unspecified
      if (wr_hit(`ASF_REG_HDR)) begin
        hdr_reg       <= reg_wdata_i[7:0];
        hdr_given_reg <= 1'b1;
      end
    end
  end

  // point count and play gate
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      points_reg  <= 16'h0000;
      play_ok_reg <= 1'b1;
    end else begin
      if (wr_hit(`ASF_REG_CTRL) && reg_wdata_i[`ASF_CTRL_START_BIT]) begin
        points_reg  <= 16'h0000;
        play_ok_reg <= 1'b1;
      end else if (point_done && points_reg != 16'hffff) begin
        points_reg <= points_reg + 16'h0001;
      end
      if (short_evt) begin
        play_ok_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_reg <= '0;
    end else begin
      // set wins over a same-cycle write-one clear
      status_reg <= (status_reg
                   & ~(wr_hit(`ASF_REG_STATUS) ? reg_wdata_i[`ASF_IRQ_W-1:0] : '0))
                   | evt;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_reg & mask_reg);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `ASF_REG_CTRL:   reg_rdata_o <= {27'h0, hdr_given_reg, 2'b00, legacy_reg, en_reg};
        `ASF_REG_SCALE:  reg_rdata_o <= {24'h0, scale_reg};
        `ASF_REG_STATUS: reg_rdata_o <= {29'h0, status_reg};
        `ASF_REG_MASK:   reg_rdata_o <= {29'h0, mask_reg};
        `ASF_REG_POINTS: reg_rdata_o <= {15'h0, play_ok_reg, points_reg};
        `ASF_REG_HDR:    reg_rdata_o <= {24'h0, hdr_reg};
        default:         reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end
endmodule // asf_formatter
`default_nettype wire

// ===== verif/asf_fmt_chk.sv
/*
  port-level checks of the sample formatter, bound into every instance.
  assumes one clock with an active-high asynchronous reset.
*/
`default_nettype none
`include "asf_cfg.svh"
module asf_fmt_chk
  import asf_pkg::*;
(
  input wire logic                   core_clk_i,
  input wire logic                   rst_i,
  input wire logic [`ASF_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0]            reg_wdata_i,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire logic [31:0]            reg_rdata_o,
  input wire logic                   iq_ready_o,
  input wire logic                   mark_ready_o,
  input wire asf_sample_t            samp_i_o,
  input wire asf_sample_t            samp_q_o,
  input wire logic [3:0]             samp_mark_o,
  input wire logic                   samp_valid_o,
  input wire logic                   samp_ready_i,
  input wire logic [3:0]             marker_trig_o,
  input wire logic                   event_primary_o,
  input wire logic                   event_aux_o,
  input wire logic                   irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data not zero outside read cycle");
  rd_unmap_a: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) > `ASF_REG_HDR |-> reg_rdata_o == '0)
    else $error("unmapped read not zero");
  samp_hold_a: assert property (
    samp_valid_o && !samp_ready_i |=> samp_valid_o && $stable(samp_i_o)
      && $stable(samp_q_o) && $stable(samp_mark_o))
    else $error("held sample changed before accept");
  trig_with_a: assert property (
    $rose(samp_valid_o) |-> marker_trig_o == samp_mark_o)
    else $error("trigger outputs differ from sample markers");
  evt_primary_a: assert property (event_primary_o == marker_trig_o[0])
    else $error("primary event not first marker");
  evt_aux_a: assert property (event_aux_o == |marker_trig_o)
    else $error("aux event not any marker");
  // mask register lands one edge after the write, irq one edge after that
  irq_off_a: assert property (
    reg_wr_i && reg_addr_i == `ASF_REG_MASK && reg_wdata_i[2:0] == 3'h0 |=> ##1 !irq_o)
    else $error("interrupt high with all events masked");
  // ready is registered from the enable, so it follows one edge later
  ready_off_a: assert property (
    reg_wr_i && reg_addr_i == `ASF_REG_CTRL && !reg_wdata_i[`ASF_CTRL_EN_BIT]
      |=> ##1 (!iq_ready_o && !mark_ready_o))
    else $error("input ready while disabled");

  cover property (samp_valid_o && !samp_ready_i);
  cover property ($rose(irq_o));
  cover property (marker_trig_o == 4'hf);
endmodule // asf_fmt_chk

bind asf_formatter asf_fmt_chk u_chk (
  .core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .iq_ready_o, .mark_ready_o, .samp_i_o, .samp_q_o, .samp_mark_o, .samp_valid_o,
  .samp_ready_i, .marker_trig_o, .event_primary_o, .event_aux_o, .irq_o
);
`default_nettype wire

// ===== verif/asf_dac_sink.sv
/*
  converter-path model: accepts samples, stalls on request, records them.
  assumes the formatter's clock and reset.
*/
`default_nettype none
module asf_dac_sink
  import asf_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  input  wire asf_sample_t samp_i_i,
  input  wire asf_sample_t samp_q_i,
  input  wire logic [3:0]  mark_i,
  input  wire logic        valid_i,
  output logic             ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] cap[$];
  logic [1:0]  ph;
  // slow mode accepts one cycle in four to keep a sample held
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph <= 2'h0;
      ready_o <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      ready_o <= !slow_i || ph == 2'h3;
      if (valid_i && ready_o) cap.push_back({mark_i, samp_i_i, samp_q_i});
    end
  end
endmodule // asf_dac_sink
`default_nettype wire

// ===== verif/tb_top.sv
/*
  self-checking bench of the sample formatter: register and byte tasks.
  assumes the checker binds itself and the sink model records samples.
*/
`default_nettype none
`include "asf_cfg.svh"
module tb_top
  import asf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  iq_byte_i = 8'h00;
  logic [7:0]  mark_byte_i = 8'h00;
  logic        iq_valid_i = 1'b0;
  logic        mark_valid_i = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        iq_ready_o, mark_ready_o, samp_valid_o, samp_ready_i;
  logic        event_primary_o, event_aux_o, irq_o;
  asf_sample_t samp_i_o, samp_q_o;
  logic [3:0]  samp_mark_o, marker_trig_o;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [15:0] vi [4] = '{16'h1234, 16'h7fff, 16'h0000, 16'hff00};
  logic [15:0] vq [4] = '{16'hfedc, 16'h8000, 16'h0001, 16'h00ff};
  logic [7:0]  vm [4] = '{8'h01, 8'hfa, 8'h0f, 8'h54};
  logic [15:0] lv [3] = '{16'h3fff, 16'h0000, 16'h2000};
  // legacy codes: top, bottom and middle of the 14-bit range, in 16-bit steps of four
  logic [15:0] lx [3] = '{16'h7ffc, 16'h8000, 16'h0000};

  always #12.5 core_clk_i = ~core_clk_i;

  asf_formatter dut (
    .core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .iq_byte_i, .iq_valid_i, .iq_ready_o, .mark_byte_i, .mark_valid_i, .mark_ready_o,
    .samp_i_o, .samp_q_o, .samp_mark_o, .samp_valid_o, .samp_ready_i, .marker_trig_o,
    .event_primary_o, .event_aux_o, .irq_o
  );
  asf_dac_sink snk (
    .core_clk_i, .rst_i, .slow_i(slow), .samp_i_i(samp_i_o), .samp_q_i(samp_q_o),
    .mark_i(samp_mark_o), .valid_i(samp_valid_o), .ready_o(samp_ready_i)
  );

  task automatic finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk(36'(reg_rdata_o), 36'(exp));
    @(posedge core_clk_i);
  endtask
  task automatic irqc(input logic exp);
    @(negedge core_clk_i);
    chk(36'(irq_o), 36'(exp));
    @(posedge core_clk_i);
  endtask
  // ready is registered, so its level at the falling edge is what the next edge samples
  task automatic put_iq(input logic [7:0] b);
    iq_byte_i <= b;
    iq_valid_i <= 1'b1;
    do @(negedge core_clk_i); while (iq_ready_o !== 1'b1);
    @(posedge core_clk_i);
  endtask
  task automatic put_mk(input logic [7:0] b);
    mark_byte_i <= b;
    mark_valid_i <= 1'b1;
    do @(negedge core_clk_i); while (mark_ready_o !== 1'b1);
    @(posedge core_clk_i);
  endtask
  task automatic pt(input logic [15:0] i, input logic [15:0] q, input logic [7:0] m);
    fork
      begin
        put_iq(i[15:8]);
        put_iq(i[7:0]);
        put_iq(q[15:8]);
        put_iq(q[7:0]);
        iq_valid_i <= 1'b0;
      end
      begin
        put_mk(m);
        mark_valid_i <= 1'b0;
      end
    join
    @(posedge core_clk_i);
  endtask
  task automatic get(input logic [15:0] i, input logic [15:0] q, input logic [3:0] m);
    repeat (40) if (snk.cap.size() == 0) @(posedge core_clk_i);
    chk(snk.cap.size() ? snk.cap.pop_front() : 'x, {m, i, q});
  endtask
  task automatic run(input int n, input logic [31:0] st);
    wr(`ASF_REG_STATUS, 32'h0000_0007);
    wr(`ASF_REG_CTRL, 32'h0000_0005);
    rc(`ASF_REG_HDR, 32'h0000_0000);
    for (int k = 0; k < n; k++) begin
      pt(16'(k * 256), 16'(-k), 8'(k) | 8'hf0);
      get(16'(k * 256), 16'(-k), 4'(k));
    end
    wr(`ASF_REG_CTRL, 32'h0000_0009);
    rc(`ASF_REG_STATUS, st);
  endtask

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rc(`ASF_REG_SCALE, 32'h0000_0046);
    rc(`ASF_REG_MASK, 32'h0000_0000);
    rc(`ASF_REG_STATUS, 32'h0000_0000);
    rc(4'hf, 32'h0000_0000);
    wr(`ASF_REG_SCALE, 32'h0000_00c8);
    rc(`ASF_REG_SCALE, 32'h0000_0064);
    wr(`ASF_REG_CTRL, 32'h0000_0005);
    for (int k = 0; k < 4; k++) begin
      pt(vi[k], vq[k], vm[k]);
      get(vi[k], vq[k], vm[k][3:0]);
    end
    wr(`ASF_REG_CTRL, 32'h0000_0003);
    for (int k = 0; k < 3; k++) begin
      pt(lv[k], lv[k], 8'h00);
      get(lx[k], lx[k], 4'h0);
    end
    wr(`ASF_REG_CTRL, 32'h0000_0001);
    wr(`ASF_REG_SCALE, 32'h0000_0032);
    pt(16'h4000, 16'h8000, 8'h00);
    get(16'h2000, 16'hc000, 4'h0);
    wr(`ASF_REG_SCALE, 32'h0000_0064);
    wr(`ASF_REG_STATUS, 32'h0000_0007);
    pt(16'h0010, 16'h0010, 8'h00);
    get(16'h0010, 16'h0010, 4'h0);
    rc(`ASF_REG_STATUS, 32'h0000_0000);
    pt(16'h7fff, 16'h0010, 8'h00);
    get(16'h7fff, 16'h0010, 4'h0);
    rc(`ASF_REG_STATUS, 32'h0000_0001);
    irqc(1'b0);
    wr(`ASF_REG_MASK, 32'h0000_0001);
    irqc(1'b1);
    wr(`ASF_REG_STATUS, 32'h0000_0001);
    irqc(1'b0);
    slow <= 1'b1;
    run(59, 32'h0000_0002);
    pt(16'h0000, 16'h0000, 8'h00);
    repeat (40) @(posedge core_clk_i);
    chk(36'(snk.cap.size()), 36'h0);
    run(60, 32'h0000_0004);
    rc(`ASF_REG_POINTS, 32'h0001_003c);
    // header given, then a new waveform without one keeps the old value
    wr(`ASF_REG_HDR, 32'h0000_005a);
    rc(`ASF_REG_CTRL, 32'h0000_0011);
    wr(`ASF_REG_CTRL, 32'h0000_0005);
    rc(`ASF_REG_CTRL, 32'h0000_0001);
    rc(`ASF_REG_HDR, 32'h0000_005a);
    wr(`ASF_REG_CTRL, 32'h0000_0000);
    wr(`ASF_REG_MASK, 32'h0000_0000);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
